// ### core/ams_cfg.svh
/*
 Offsets, field positions and reset values of the input multiplexer sequencer.
 Assumes a 32-bit AHB-Lite register bus and one 100 MHz core clock.
*/
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH

// --------------------------------------------------
// Register byte offsets
// --------------------------------------------------
`define AMS_REG_SEL_LO 14'h0000
`define AMS_REG_SEL_HI 14'h0004
`define AMS_REG_ALT_LO 14'h0008
`define AMS_REG_ALT_HI 14'h000C
`define AMS_REG_CTRL 14'h0010
`define AMS_REG_STATUS 14'h0014
`define AMS_REG_CONFIG 14'h2020

// --------------------------------------------------
// Control and config fields
// --------------------------------------------------
`define AMS_CTRL_SPF_LSB 0
`define AMS_CTRL_FLEN_LSB 4
`define AMS_CTRL_CHOP_LSB 8
`define AMS_CTRL_DIFFA_BIT 12
`define AMS_CTRL_DIFFB_BIT 13
`define AMS_CTRL_ALT_BIT 16
`define AMS_CFG_BME_BIT 6

// --------------------------------------------------
// Reset values and limits
// --------------------------------------------------
`define AMS_SEL_LO_RST 32'h00003210
`define AMS_ALT_LO_RST 32'h00003B1A
`define AMS_CTRL_RST 32'h00000004
`define AMS_MAX_STATES 4'hA
`define AMS_SLOTS 10
`define AMS_DATA_W 32

`endif

// ### core/ams_pkg.sv
/*
 Types shared by the multiplexer sequencer.
 Assumes ams_cfg.svh supplies the widths.
*/
`include "ams_cfg.svh"

package ams_pkg;

    typedef enum logic [1:0] {
        AMS_IDLE = 2'b00,
        AMS_CONV = 2'b01,
        AMS_WAIT = 2'b10,
        AMS_SYNC = 2'b11
    } ams_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [`AMS_DATA_W-1:0] data;
    } ams_result_s;

endpackage

// ### core/ams_mux_seq.sv
/*
 Input multiplexer sequencer with AHB-Lite register slave.
 Assumes a filter that answers each start with one done pulse and its result,
 and a slow 32 kHz clock arriving asynchronously on a pin.
*/
`include "ams_cfg.svh"

module ams_mux_seq
    import ams_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic slow_clock_32k,
    input wire logic filter_done_flag,
    input wire logic [`AMS_DATA_W-1:0] filterData,
    output logic filter_start_cmd,
    output logic [1:0] filter_length_select,
    output logic [3:0] muxSelect,
    output ams_result_s resultWrite,
    output logic resultValid,
    output logic frame_sync_pulse,
    output logic ceStart,
    output logic chop_polarity,
    output logic [1:0] diffSelect,
    output logic [1:0] pairSwap,
    output logic batteryActive
);

    // --------------------------------------------------
    // Helpers
    // --------------------------------------------------
    function automatic logic [3:0] slotField(input logic [63:0] list, input logic [3:0] idx);
        slotField = list[idx*4 +: 4];
    endfunction

    function automatic logic [3:0] statesOf(input logic [3:0] spf);
        if (spf == 4'h0) begin
            statesOf = 4'h1;
        end else if (spf > `AMS_MAX_STATES) begin
            statesOf = `AMS_MAX_STATES;
        end else begin
            statesOf = spf;
        end
    endfunction

    // --------------------------------------------------
    // Registers and state
    // --------------------------------------------------
    logic [63:0] selList_q;
    logic [63:0] altList_q;
    logic [31:0] ctrl_q;
    logic bme_q;
    logic altBit_q;
    logic altPending_q;
    logic altActive_q;
    ams_state_e state_q;
    logic [3:0] slot_q;
    logic [3:0] frameStates_q;
    logic wrPhase_q;
    logic [13:0] wrAddr_q;
    logic [2:0] slowSync_q;
    logic slowLevel_q;
    logic slowRise;
    logic altEdge;
    logic addrPhase;
    logic [3:0] nStates;
    logic lastSlot;
    logic frameStart;
    logic nextStart;
    logic [3:0] startSlot;
    logic startAlt;

    assign addrPhase = hsel && hready && htrans[1];
    assign altEdge = wrPhase_q && (wrAddr_q == `AMS_REG_CTRL) && hwdata[`AMS_CTRL_ALT_BIT] && !altBit_q;
    assign nStates = statesOf(ctrl_q[`AMS_CTRL_SPF_LSB +: 4]);
    assign lastSlot = (slot_q + 4'h1) >= frameStates_q;

    // --------------------------------------------------
    // Slow clock synchroniser
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            slowSync_q <= 3'h0;
            slowLevel_q <= 1'b0;
        end else begin
            slowSync_q <= {slowSync_q[1:0], slow_clock_32k};
            if (slowSync_q[1] == slowSync_q[2]) begin
                slowLevel_q <= slowSync_q[2];
            end
        end
    end

    assign slowRise = (slowSync_q[1] == slowSync_q[2]) && slowSync_q[2] && !slowLevel_q;

    // --------------------------------------------------
    // AHB-Lite slave
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPhase_q <= 1'b0;
            wrAddr_q <= 14'h0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            wrPhase_q <= addrPhase && hwrite;
            wrAddr_q <= {haddr[13:2], 2'b00};
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPhase && !hwrite) begin
                case ({haddr[13:2], 2'b00})
                    `AMS_REG_SEL_LO: hrdata <= selList_q[31:0];
                    `AMS_REG_SEL_HI: hrdata <= {24'h000000, selList_q[39:32]};
                    `AMS_REG_ALT_LO: hrdata <= altList_q[31:0];
                    `AMS_REG_ALT_HI: hrdata <= {24'h000000, altList_q[39:32]};
                    `AMS_REG_CTRL: hrdata <= ctrl_q;
                    `AMS_REG_STATUS: hrdata <= {23'h000000, altPending_q, altActive_q, chop_polarity,
                                                state_q, slot_q};
                    `AMS_REG_CONFIG: hrdata <= {25'h0000000, bme_q, 6'h00};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            selList_q <= {32'h00000000, `AMS_SEL_LO_RST};
            altList_q <= {32'h00000000, `AMS_ALT_LO_RST};
            ctrl_q <= `AMS_CTRL_RST;
            bme_q <= 1'b0;
        end else if (wrPhase_q) begin
            case (wrAddr_q)
                `AMS_REG_SEL_LO: selList_q[31:0] <= hwdata;
                `AMS_REG_SEL_HI: selList_q[39:32] <= hwdata[7:0];
                `AMS_REG_ALT_LO: altList_q[31:0] <= hwdata;
                `AMS_REG_ALT_HI: altList_q[39:32] <= hwdata[7:0];
                `AMS_REG_CTRL: ctrl_q <= {15'h0000, hwdata[16:0]};
                `AMS_REG_CONFIG: bme_q <= hwdata[`AMS_CFG_BME_BIT];
                default: ;
            endcase
        end
    end

    // --------------------------------------------------
    // Alternate frame request
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            altBit_q <= 1'b0;
            altPending_q <= 1'b0;
        end else begin
            altBit_q <= ctrl_q[`AMS_CTRL_ALT_BIT];
            if (frameStart) begin
                altPending_q <= 1'b0;
            end else if (altEdge) begin
                altPending_q <= 1'b1;
            end
        end
    end

    // --------------------------------------------------
    // Sequencer
    // --------------------------------------------------
    assign frameStart = slowRise && ((state_q == AMS_IDLE) || (state_q == AMS_SYNC));
    assign nextStart = slowRise && (state_q == AMS_WAIT) && !lastSlot;
    assign startSlot = frameStart ? 4'h0 : slot_q + 4'h1;
    assign startAlt = frameStart ? (altPending_q || altEdge) : altActive_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= AMS_IDLE;
            slot_q <= 4'h0;
            frameStates_q <= 4'h1;
            altActive_q <= 1'b0;
            filter_start_cmd <= 1'b0;
            muxSelect <= 4'h0;
        end else begin
            filter_start_cmd <= 1'b0;
            case (state_q)
                AMS_IDLE, AMS_SYNC: begin
                    if (frameStart) begin
                        state_q <= AMS_CONV;
                    end
                end
                AMS_CONV: begin
                    if (filter_done_flag) begin
                        state_q <= AMS_WAIT;
                    end
                end
                AMS_WAIT: begin
                    if (slowRise) begin
                        state_q <= lastSlot ? AMS_SYNC : AMS_CONV;
                    end
                end
                default: state_q <= AMS_IDLE;
            endcase
            if (frameStart) begin
                frameStates_q <= nStates;
            end
            if (frameStart || nextStart) begin
                slot_q <= startSlot;
                altActive_q <= startAlt;
                filter_start_cmd <= 1'b1;
                muxSelect <= startAlt ? slotField(altList_q, startSlot)
                                      : slotField(selList_q, startSlot);
            end
        end
    end

    // --------------------------------------------------
    // Filter results
    // --------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resultValid <= 1'b0;
            resultWrite <= '0;
            filter_length_select <= 2'h0;
        end else begin
            filter_length_select <= ctrl_q[`AMS_CTRL_FLEN_LSB +: 2];
            resultValid <= (state_q == AMS_CONV) && filter_done_flag;
            if ((state_q == AMS_CONV) && filter_done_flag) begin
                resultWrite.addr <= muxSelect;
                resultWrite.data <= filterData;
            end
        end
    end

    // --------------------------------------------------
    // Frame sync, chopping and front-end controls
    // --------------------------------------------------
    logic syncEntry;
    logic [1:0] chopMode;
    assign syncEntry = (state_q == AMS_WAIT) && slowRise && lastSlot;
    assign chopMode = ctrl_q[`AMS_CTRL_CHOP_LSB +: 2];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            frame_sync_pulse <= 1'b0;
            ceStart <= 1'b0;
            chop_polarity <= 1'b0;
            pairSwap <= 2'h0;
            diffSelect <= 2'h0;
            batteryActive <= 1'b0;
        end else begin
            ceStart <= syncEntry;
            if (syncEntry) begin
                frame_sync_pulse <= 1'b1;
            end else if (frameStart) begin
                frame_sync_pulse <= 1'b0;
            end
            if (syncEntry) begin
                case (chopMode)
                    2'h1: chop_polarity <= 1'b0;
                    2'h2: chop_polarity <= 1'b1;
                    2'h0: chop_polarity <= (altPending_q || altEdge) ? chop_polarity : !chop_polarity;
                    default: chop_polarity <= !chop_polarity;
                endcase
                pairSwap <= ~pairSwap & diffSelect;
            end
            diffSelect <= {ctrl_q[`AMS_CTRL_DIFFB_BIT], ctrl_q[`AMS_CTRL_DIFFA_BIT]};
            batteryActive <= bme_q;
        end
    end

    // --------------------------------------------------
    // Checks
    // --------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_start_on_edge: assert property (filter_start_cmd |-> $past(slowRise))
        else $error("filter start without slow edge");
    chk_frame_from_zero: assert property ((state_q == AMS_SYNC && slowRise)
        |=> (slot_q == 4'h0 && filter_start_cmd))
        else $error("frame did not start at slot zero");
    chk_regular_select: assert property ((filter_start_cmd && !altActive_q)
        |-> muxSelect == slotField($past(selList_q), slot_q))
        else $error("regular selection wrong");
    chk_alt_select: assert property ((filter_start_cmd && altActive_q)
        |-> muxSelect == slotField($past(altList_q), slot_q))
        else $error("alternate selection wrong");
    chk_alt_capture: assert property (altEdge |=> (altPending_q || altActive_q))
        else $error("alternate request lost");
    chk_pending_clear: assert property (frameStart |=> !altPending_q)
        else $error("alternate request used twice");
    chk_slot_bound: assert property (slot_q < frameStates_q || state_q == AMS_IDLE)
        else $error("slot beyond frame length");
    chk_sync_high: assert property ($rose(ceStart) |-> frame_sync_pulse ##1 frame_sync_pulse)
        else $error("frame sync not held");
    chk_ce_in_sync: assert property (ceStart |-> frame_sync_pulse)
        else $error("compute pass outside frame sync");
    chk_sync_clear: assert property (frameStart |=> !frame_sync_pulse)
        else $error("frame sync still high in frame");
    chk_ce_once: assert property (ceStart |=> !ceStart)
        else $error("compute pass launched twice");
    chk_start_pulse: assert property (filter_start_cmd |=> !filter_start_cmd)
        else $error("filter start longer than one cycle");
    chk_wait_hold: assert property ((state_q == AMS_WAIT && !slowRise) |=> state_q == AMS_WAIT)
        else $error("state advanced without slow edge");
    chk_chop_fixed: assert property ((syncEntry && chopMode == 2'h1) |=> !chop_polarity)
        else $error("chop polarity not held low");
    chk_result_store: assert property ((state_q == AMS_CONV && filter_done_flag)
        |=> resultValid && resultWrite.addr == muxSelect)
        else $error("result not stored");
    chk_battery_gate: assert property (batteryActive |-> $past(bme_q))
        else $error("battery path active while disabled");

    cov_alt_frame: cover property (filter_start_cmd && altActive_q && slot_q == 4'h0);
    cov_frame_sync: cover property ($rose(frame_sync_pulse));
    cov_result: cover property (resultValid);
    cov_ten_states: cover property (filter_start_cmd && slot_q == 4'h9);
    cov_pair_swap: cover property ($rose(pairSwap[0]));

endmodule

// ### testbench/ams_filter_model.sv
/*
 Decimation filter partner: answers each start with one done pulse and data.
 Assumes the sequencer's core clock and a slow clock of SLOW_CYC core cycles.
*/
module ams_filter_model #(
    parameter int SLOW_CYC = 40
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic filter_start_cmd,
    input wire logic [1:0] filter_length_select,
    input wire logic [3:0] muxSelect,
    input wire logic slowAnswer,
    output logic filter_done_flag,
    output logic [31:0] filterData
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = -1;
    logic [3:0] sel = 4'h0;
    initial filter_done_flag = 1'b0;
    initial filterData = 32'h00000000;
    // Conversion time grows with the filter length; data is junk outside done
    always @(posedge core_clk) begin
        filter_done_flag <= (!rst && cnt == 0);
        filterData <= (!rst && cnt == 0) ? {24'hA5A5A5, 4'h0, sel} : ~filterData;
        if (rst || cnt == 0) begin
            cnt <= -1;
        end else if (filter_start_cmd) begin
            cnt <= filter_length_select * SLOW_CYC + (slowAnswer ? 30 : 5);
            sel <= muxSelect;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### testbench/test_ams_mux_seq.sv
/*
 Self-checking bench for the multiplexer sequencer.
 Assumes the filter model as far side and a slow clock shortened to 40 core cycles.
*/
`include "ams_cfg.svh"

module test_ams_mux_seq
    import ams_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst, hsel, hwrite, hready, slowClk, slowPrev, slowAnswer;
    logic [31:0] haddr, hwdata, hrdata, filterData, q;
    logic [2:0] hsize;
    logic [1:0] htrans, filter_length_select, diffSelect, pairSwap, p;
    logic [3:0] muxSelect;
    logic hreadyout, hresp, filter_done_flag, filter_start_cmd, resultValid;
    logic frame_sync_pulse, ceStart, chop_polarity, batteryActive;
    ams_result_s resultWrite;
    int n_mismatch = 0, checks_done = 0, sinceRise = 0, nCe = 0;
    logic [31:0] rowCtrl [5] = '{32'h00000101, 32'h00002213, 32'h0000112A, 32'h00000200, 32'h0000030F};
    logic [31:0] rowSel [5] = '{32'h76543210, 32'h87654321, 32'h76543210, 32'h00000003, 32'h12345678};
    int rowN [5] = '{1, 3, 10, 1, 10};
    logic rowChop [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    assign hready = hreadyout;

    ams_mux_seq i_ams_mux_seq (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .slow_clock_32k(slowClk), .filter_done_flag(filter_done_flag), .filterData(filterData),
        .filter_start_cmd(filter_start_cmd), .filter_length_select(filter_length_select), .muxSelect(muxSelect),
        .resultWrite(resultWrite), .resultValid(resultValid), .frame_sync_pulse(frame_sync_pulse),
        .ceStart(ceStart), .chop_polarity(chop_polarity), .diffSelect(diffSelect), .pairSwap(pairSwap),
        .batteryActive(batteryActive));
    ams_filter_model i_ams_filter_model (.core_clk(core_clk), .rst(rst), .filter_start_cmd(filter_start_cmd),
        .filter_length_select(filter_length_select), .muxSelect(muxSelect), .slowAnswer(slowAnswer),
        .filter_done_flag(filter_done_flag), .filterData(filterData));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        slowClk = 1'b0;
        #3;
        forever #200 slowClk = ~slowClk;
    end
    // Core cycles since the slow pin last rose
    always @(posedge core_clk) begin
        slowPrev <= slowClk;
        sinceRise <= (slowClk && !slowPrev) ? 0 : sinceRise + 1;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_ready();
        int t;
        t = 0;
        do begin
            @(posedge core_clk);
            t++;
        end while (hreadyout !== 1'b1 && t < 100);
        if (t >= 100) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic step(inout int t);
        @(posedge core_clk);
        #1;
        t++;
        if (ceStart === 1'b1) nCe++;
    endtask
    // Watches one whole frame after the next frame sync
    task automatic run_frame(input logic [39:0] lst, input int n, input logic chopExp);
        int k, t, s;
        logic [3:0] sel;
        k = 0;
        t = 0;
        while (frame_sync_pulse !== 1'b1 && t < 9000) step(t);
        s = t;
        while (frame_sync_pulse !== 1'b0 && t < 9000) step(t);
        if (s > 0) check((t - s) inside {[30:45]}, 1'b1);
        nCe = 0;
        while (frame_sync_pulse !== 1'b1 && t < 9000) begin
            if (filter_start_cmd === 1'b1) begin
                check(muxSelect, lst[4 * k +: 4]);
                check(sinceRise inside {[1:8]}, 1'b1);
                k++;
            end
            if (resultValid === 1'b1) begin
                sel = lst[4 * (k - 1) +: 4];
                check(resultWrite, {sel, 24'hA5A5A5, 4'h0, sel});
            end
            step(t);
        end
        repeat (3) step(t);
        check(k, n);
        check(nCe, 1);
        check(chop_polarity, chopExp);
        if (t >= 9000) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'b00;
        hsize = 3'h2;
        slowAnswer = 1'b0;
        slowPrev = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({filter_start_cmd, frame_sync_pulse, ceStart, resultValid, muxSelect, hreadyout, hresp},
              10'h002);
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        ahb(1'b0, `AMS_REG_SEL_LO, 32'h0, q);
        check(q, `AMS_SEL_LO_RST);
        ahb(1'b0, `AMS_REG_ALT_LO, 32'h0, q);
        check(q, `AMS_ALT_LO_RST);
        ahb(1'b0, `AMS_REG_CTRL, 32'h0, q);
        check(q, `AMS_CTRL_RST);
        ahb(1'b0, 32'h00000100, 32'h0, q);
        check(q, 32'h0);
        for (int b = 1; b >= 0; b--) begin
            ahb(1'b1, `AMS_REG_CONFIG, b << `AMS_CFG_BME_BIT, q);
            repeat (2) @(posedge core_clk);
            #1;
            check(batteryActive, b[0]);
        end
        ahb(1'b1, `AMS_REG_SEL_HI, 32'h00000098, q);
        for (int r = 0; r < 5; r++) begin
            slowAnswer <= r[0];
            ahb(1'b1, `AMS_REG_SEL_LO, rowSel[r], q);
            ahb(1'b1, `AMS_REG_CTRL, rowCtrl[r], q);
            run_frame({8'h98, rowSel[r]}, rowN[r], rowChop[r]);
            check(filter_length_select, rowCtrl[r][5:4]);
            check(diffSelect, rowCtrl[r][13:12]);
        end
        ahb(1'b1, `AMS_REG_CTRL, 32'h00001104, q);
        run_frame({8'h98, rowSel[4]}, 4, 1'b0);
        p = pairSwap;
        run_frame({8'h98, rowSel[4]}, 4, 1'b0);
        check(pairSwap ^ p, 2'b01);
        ahb(1'b1, `AMS_REG_ALT_LO, 32'h00003B1A, q);
        ahb(1'b1, `AMS_REG_CTRL, 32'h00011004, q);
        ahb(1'b1, `AMS_REG_CTRL, 32'h00001004, q);
        run_frame({8'h00, 32'h00003B1A}, 4, 1'b1);
        run_frame({8'h98, rowSel[4]}, 4, 1'b0);
        tally_and_finish();
    end
endmodule
